// [hw/wcg_guard.sv]
// Watchdog configuration guard with APB access and fuse-selected safety levels.
// Limitation: the level is latched once after reset; fuse changes need a reset.
// Trade-off: pready is tied high, so the window is counted in plain clock edges.
//
// Decided for this implementation: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module wcg_guard
    import wcg_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic wdog_always_on_fuse,
    input wire logic legacy_compat_fuse,
    output logic wdog_run,
    output logic [2:0] wdog_timeout_sel,
    output logic [21:0] wdog_period
);
    import wcg_pkg::*;

    ////////////////////////////////////////////////////////////////////////////

    typedef struct packed {
        // Two-stage fuse synchroniser and the marker of its filled stages.
        logic [1:0]  fuse_m;
        logic [1:0]  fuse_s;
        logic [1:0]  fill;
        // Latched safety level.
        logic        lvl_valid;
        wcg_level_t  level;
        // Configuration as seen by the watchdog counter.
        logic        run;
        logic [2:0]  sel;
        logic [21:0] period;
        // Read data registered in the setup cycle.
        logic [31:0] rdata;
    } wcg_state_t;

    // One copy holds the state, the other its next value.
    wcg_state_t s_q;
    wcg_state_t s_d;

    // Decoded bus and window signals.
    logic acc;
    logic wr_ctrl;
    logic mapped;
    logic win_open;
    logic [2:0] win_cnt;
    logic arm_wr;
    logic commit_wr;
    logic w_run;
    logic w_arm;
    logic [2:0] w_sel;
    wcg_level_t lvl_now;
    logic rd_setup;

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode.

    // The access phase is the only cycle in which a write may change state.
    assign acc = psel && penable;
    assign mapped = (paddr == WCG_CTRL_ADDR) || (paddr == WCG_STAT_ADDR);
    assign wr_ctrl = acc && pwrite && (paddr == WCG_CTRL_ADDR) && s_q.lvl_valid;
    assign w_run = pwdata[WCG_RUN_POS];
    assign w_arm = pwdata[WCG_ARM_POS];
    assign w_sel = pwdata[WCG_SEL_LSB +: 3];
    assign arm_wr = wr_ctrl && w_arm && w_run;
    assign commit_wr = wr_ctrl && !w_arm && win_open;
    // Read data is built in the setup cycle so that it stands, registered,
    // through the whole access phase with no wait state.
    assign rd_setup = psel && !penable && !pwrite;

    ////////////////////////////////////////////////////////////////////////////
    // Fuse synchroniser, level latch and control register update.

    // Fuses are pins from outside the clock domain; they pass two flops.
    always_comb begin
        s_d = s_q;
        s_d.fuse_m = {wdog_always_on_fuse, legacy_compat_fuse};
        s_d.fuse_s = s_q.fuse_m;
        // Each set bit marks a synchroniser stage that holds a real fuse sample.
        s_d.fill = {s_q.fill[0], 1'b1};
        lvl_now = s_q.level;
        // Latching before the pipe is full would read the reset value of the
        // second stage and always pick level 1, whatever the fuses say.
        if (!s_q.lvl_valid && s_q.fill[1]) begin
            // Level is latched once after reset so a glitching fuse cannot unlock.
            s_d.lvl_valid = 1'b1;
            if (s_q.fuse_s[1]) begin
                lvl_now = WCG_LVL2;
            end else if (s_q.fuse_s[0]) begin
                lvl_now = WCG_LVL0;
            end else begin
                lvl_now = WCG_LVL1;
            end
            s_d.level = lvl_now;
            s_d.run = (lvl_now == WCG_LVL2);
        end
        // Writes are refused until the level is latched; wr_ctrl carries that.
        if (wr_ctrl) begin
            case (s_q.level)
                WCG_LVL0: begin
                    // Level 0: the selector is open; only clearing run needs the window.
                    s_d.sel = w_sel;
                    if (w_run) begin
                        s_d.run = 1'b1;
                    end else if (win_open && !w_arm) begin
                        s_d.run = 1'b0;
                    end
                end
                WCG_LVL1: begin
                    // Level 1: enabling is free; any other change waits for a commit.
                    if (w_run) begin
                        s_d.run = 1'b1;
                    end
                    if (commit_wr) begin
                        s_d.run = w_run;
                        s_d.sel = w_sel;
                    end
                end
                WCG_LVL2: begin
                    // Level 2: run is pinned high below, so a commit moves the selector only.
                    if (commit_wr) begin
                        s_d.sel = w_sel;
                    end
                end
                default: begin
                    // An unused level code fails safe with the watchdog running.
                    s_d.run = 1'b1;
                end
            endcase
        end
        // Pinned last so that no write path can ever drop run at level 2.
        if (s_q.level == WCG_LVL2 && s_q.lvl_valid) begin
            s_d.run = 1'b1;
        end
        // The period follows the next selector so both outputs move on one edge.
        s_d.period = WCG_BASE_PERIOD << s_d.sel;
        // Bits outside the fields, and unmapped addresses, read as zero.
        s_d.rdata = WCG_UNMAPPED_DATA;
        if (rd_setup) begin
            if (paddr == WCG_CTRL_ADDR) begin
                s_d.rdata[WCG_SEL_LSB +: 3] = s_q.sel;
                s_d.rdata[WCG_RUN_POS] = s_q.run;
                s_d.rdata[WCG_ARM_POS] = win_open;
            end else if (paddr == WCG_STAT_ADDR) begin
                // The status view shows the latched level and the live window count.
                s_d.rdata[WCG_STAT_LVL_LSB +: 2] = s_q.level;
                s_d.rdata[WCG_STAT_ARM_POS] = win_open;
                s_d.rdata[WCG_STAT_CNT_LSB +: 3] = win_cnt;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register.

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '{fuse_m: 2'h0, fuse_s: 2'h0, fill: 2'h0,
                     lvl_valid: 1'b0, level: WCG_LVL1,
                     run: 1'b0, sel: WCG_SEL_RESET, period: WCG_BASE_PERIOD,
                     rdata: WCG_UNMAPPED_DATA};
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    // Any control write without the arm bit ends the window, armed or not.
    // The count leaves the window only for the status register.
    wcg_window #(
        .CYCLES(WCG_WINDOW_CNT)
    ) u_window (
        .pclk(pclk),
        .presetn(presetn),
        .arm(arm_wr),
        .close(wr_ctrl && !w_arm),
        .open(win_open),
        .count(win_cnt)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Outputs.

    // Zero wait states: every access completes in its first access cycle.
    assign pready = 1'b1;
    // A bad address is flagged but never stalls the bus.
    assign pslverr = acc && !mapped;
    // Data outputs all come straight from the state register.
    assign prdata = s_q.rdata;
    assign wdog_run = s_q.run;
    assign wdog_timeout_sel = s_q.sel;
    assign wdog_period = s_q.period;
endmodule : wcg_guard
`default_nettype wire

// [hw/wcg_pkg.sv]
// Package with register layout, fuse levels and timing for the watchdog config guard.
package wcg_pkg;

    // Register byte addresses on the APB bus.
    localparam logic [11:0] WCG_CTRL_ADDR = 12'h000;
    localparam logic [11:0] WCG_STAT_ADDR = 12'h004;

    // Field positions in the control register.
    localparam int WCG_SEL_LSB = 0;
    localparam int WCG_RUN_POS = 3;
    localparam int WCG_ARM_POS = 4;

    // Field positions in the status register.
    localparam int WCG_STAT_LVL_LSB = 0;
    localparam int WCG_STAT_ARM_POS = 2;
    localparam int WCG_STAT_CNT_LSB = 3;

    localparam logic [2:0] WCG_SEL_RESET = 3'h0;
    localparam logic [31:0] WCG_UNMAPPED_DATA = 32'h0000_0000;

    // Window length in clock cycles after an arming write.
    localparam int WCG_WINDOW_CYCLES = 4;
    localparam logic [2:0] WCG_WINDOW_CNT = 3'(WCG_WINDOW_CYCLES);

    // Base period in watchdog-oscillator cycles for selector value 0.
    localparam logic [21:0] WCG_BASE_PERIOD = 22'h004000;

    typedef enum logic [1:0] {
        WCG_LVL0 = 2'b00,
        WCG_LVL1 = 2'b01,
        WCG_LVL2 = 2'b10
    } wcg_level_t;

    typedef struct packed {
        logic        run;
        logic [2:0]  sel;
        logic [21:0] period;
    } wcg_cfg_t;

endpackage : wcg_pkg

// [hw/wcg_window.sv]
// Countdown that holds the change window open for a fixed number of cycles.
`timescale 1ns/1ps
`default_nettype none
module wcg_window
    import wcg_pkg::*;
#(
    parameter logic [2:0] CYCLES = WCG_WINDOW_CNT
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic arm,
    input wire logic close,
    output logic open,
    output logic [2:0] count
);
    typedef struct packed {
        logic [2:0] cnt;
    } wcg_win_state_t;

    wcg_win_state_t s_q;
    wcg_win_state_t s_d;

    // The arm wins over an explicit close so a fresh arm is never lost.
    always_comb begin
        s_d = s_q;
        if (arm) begin
            s_d.cnt = CYCLES;
        end else if (close) begin
            s_d.cnt = 3'h0;
        end else if (s_q.cnt != 3'h0) begin
            s_d.cnt = s_q.cnt - 3'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign open = (s_q.cnt != 3'h0);
    assign count = s_q.cnt;
endmodule : wcg_window
`default_nettype wire

// [test/wcg_guard_properties.sv]
// Checker for the watchdog configuration guard.
`timescale 1ns/1ps
`default_nettype none
module wcg_guard_properties
    import wcg_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pslverr,
    input wire logic wdog_always_on_fuse,
    input wire logic legacy_compat_fuse,
    input wire logic wdog_run,
    input wire logic [2:0] wdog_timeout_sel,
    input wire logic [21:0] wdog_period
);
    logic wr;
    logic [2:0] age_q;
    assign wr = psel && penable && pwrite && paddr == WCG_CTRL_ADDR;
    // Edges since the last arming write; saturates so a stale window never reopens.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            age_q <= 3'h7;
        else if (wr && pwdata[4])
            age_q <= 3'h1;
        else if (age_q != 3'h7)
            age_q <= age_q + 3'h1;
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_period_sel: assert property (wdog_period == (WCG_BASE_PERIOD << wdog_timeout_sel))
        else $error("period off");
    a_run_fell: assert property ($fell(wdog_run) |-> $past(wr && !pwdata[3] && age_q < 3'h5))
        else $error("run cleared");
    a_run_rose: assert property ($rose(wdog_run) |-> $past(wr && pwdata[3]) || wdog_always_on_fuse)
        else $error("run set");
    a_sel_cause: assert property ($changed(wdog_timeout_sel) |-> $past(wr))
        else $error("sel moved");
    a_lvl2_hold: assert property (wdog_run && wdog_always_on_fuse |=> wdog_run)
        else $error("run dropped");
    a_lvl0_free: assert property (wr && legacy_compat_fuse && !wdog_always_on_fuse
        |=> wdog_timeout_sel == $past(pwdata[2:0]))
        else $error("sel refused");
    a_stale_hold: assert property (wr && !pwdata[4] && age_q > 3'h4 && !legacy_compat_fuse
        |=> $stable(wdog_timeout_sel))
        else $error("stale commit");
    a_err_map: assert property (psel && penable
        |-> pslverr == (paddr != WCG_CTRL_ADDR && paddr != WCG_STAT_ADDR))
        else $error("pslverr");
endmodule : wcg_guard_properties
bind wcg_guard wcg_guard_properties u_props (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pslverr, .wdog_always_on_fuse, .legacy_compat_fuse, .wdog_run,
    .wdog_timeout_sel, .wdog_period);
`default_nettype wire

// [test/testbench.sv]
// Self-checking testbench for the watchdog configuration guard.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import wcg_pkg::*;
    localparam logic [11:0] C = WCG_CTRL_ADDR;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic aon = 1'b0, cmp = 1'b0, pready, pslverr, wdog_run, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdv;
    logic [2:0] sel;
    logic [21:0] period;
    int error_cnt = 0, comparisons = 0;
    wcg_guard u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .wdog_always_on_fuse(aon), .legacy_compat_fuse(cmp), .wdog_run,
        .wdog_timeout_sel(sel), .wdog_period(period));
    initial forever #25 pclk = ~pclk;
    task automatic print_verdict();
        if (error_cnt == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : print_verdict
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 8);
        if (pready !== 1'b1) begin
            error_cnt++;
            print_verdict();
        end else begin
            rdv = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask : xfer
    task automatic outs(input logic run, input logic [2:0] s);
        @(negedge pclk);
        chk("run", {31'h0, wdog_run}, {31'h0, run});
        chk("sel", {29'h0, sel}, {29'h0, s});
        chk("period", {10'h0, period}, {10'h0, WCG_BASE_PERIOD << s});
    endtask : outs
    // Fuses only move under reset, since the level is latched once after release.
    task automatic rst(input logic c, input logic a, input logic [1:0] lvl);
        @(posedge pclk);
        presetn <= 1'b0;
        cmp <= c;
        aon <= a;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        xfer(1'b0, WCG_STAT_ADDR, 32'h0);
        chk("level", rdv & 32'h3, {30'h0, lvl});
    endtask : rst
    initial begin
        rst(1'b0, 1'b0, 2'h1);
        xfer(1'b1, C, 32'h08);
        outs(1'b1, 3'h0);
        xfer(1'b1, C, 32'h05);
        outs(1'b1, 3'h0);
        xfer(1'b1, C, 32'h18);
        xfer(1'b1, C, 32'h05);
        outs(1'b0, 3'h5);
        xfer(1'b1, C, 32'h18);
        xfer(1'b0, C, 32'h0);
        chk("ctrl", rdv, 32'h1D);
        repeat (4) @(posedge pclk);
        xfer(1'b1, C, 32'h02);
        outs(1'b1, 3'h5);
        rst(1'b1, 1'b0, 2'h0);
        xfer(1'b1, C, 32'h07);
        outs(1'b0, 3'h7);
        xfer(1'b1, C, 32'h0E);
        outs(1'b1, 3'h6);
        xfer(1'b1, C, 32'h02);
        outs(1'b1, 3'h2);
        xfer(1'b1, C, 32'h18);
        xfer(1'b0, WCG_STAT_ADDR, 32'h0);
        chk("stat", rdv, 32'h1C);
        xfer(1'b1, C, 32'h18);
        xfer(1'b1, C, 32'h03);
        outs(1'b0, 3'h3);
        rst(1'b0, 1'b1, 2'h2);
        outs(1'b1, 3'h0);
        xfer(1'b1, C, 32'h07);
        outs(1'b1, 3'h0);
        xfer(1'b1, C, 32'h18);
        xfer(1'b1, C, 32'h04);
        outs(1'b1, 3'h4);
        xfer(1'b0, C, 32'h0);
        chk("run_rd", rdv & 32'h8, 32'h8);
        rst(1'b1, 1'b1, 2'h2);
        xfer(1'b0, 12'h008, 32'h0);
        chk("unmapped", {err, rdv[30:0]}, 32'h80000000);
        print_verdict();
    end
endmodule : testbench
`default_nettype wire
